// >>> core/css_pkg.sv
// Summary of operation
// - with integrity check on, compute CRC over image, compare, refuse done on mismatch
// - with integrity check off, source sends constant; device skips CRC calculation
// - monitor power-down option keeps system monitor powered off
// - test-port lockout blocks boundary-scan access after configuration finishes
// - monitor test access: enabled, disabled, or status-only
// - port select routes internal config port traffic top or bottom (auto, top, bottom)
// - active reconfig suppresses global fabric hold and global set/reset
// - security none, level one, level two; level one disables readback
// - done raised in selectable phase 1..6, default 4, or keep
// - done pipeline option delays done beyond its phase
// - tristate hold released in phase 1..6, done phase or keep; default 5
// - global write enable asserted in phase 1..6, done phase or keep; default 6
// - block RAM reads and writes blocked until write enable phase
// - lock-wait phase 0..6 stalls sequencer until all clock managers lock
// - no-wait lock setting advances without checking lock
// - impedance-match phase stalls until match; auto uses 2 if calibrated I/O present
// - with error signalling on, drive error pin low on configuration error
package css_pkg;
    // ========================================
    // register map
    localparam logic [11:0] CSS_ADDR_CTRL = 12'h000;
    localparam logic [11:0] CSS_ADDR_OPT = 12'h004;
    localparam logic [11:0] CSS_ADDR_PHASE = 12'h008;
    localparam logic [11:0] CSS_ADDR_DATA = 12'h00c;
    localparam logic [11:0] CSS_ADDR_CRC = 12'h010;
    localparam logic [11:0] CSS_ADDR_STATUS = 12'h014;
    localparam logic [11:0] CSS_ADDR_CALC = 12'h018;
    // ctrl bits
    localparam int CTRL_START = 0;
    localparam int CTRL_CLEAR = 1;
    // opt bits
    localparam int OPT_CRC_EN = 0;
    localparam int OPT_MON_PD = 1;
    localparam int OPT_JTAG_LOCK = 2;
    localparam int OPT_MON_ACC_LO = 3;
    localparam int OPT_PORT_LO = 5;
    localparam int OPT_ACT_RECFG = 7;
    localparam int OPT_SEC_LO = 8;
    localparam int OPT_DONE_PIPE = 10;
    localparam int OPT_ERR_SIG = 11;
    localparam int OPT_DCI_PRESENT = 12;
    localparam logic [31:0] OPT_RESET = 32'h0000_0801;
    // phase select fields, 4 bits each
    localparam int PH_DONE_LO = 0;
    localparam int PH_TRI_LO = 4;
    localparam int PH_WE_LO = 8;
    localparam int PH_LOCK_LO = 12;
    localparam int PH_MATCH_LO = 16;
    localparam logic [31:0] PHASE_RESET = 32'h000f_f654;
    // phase codes
    localparam logic [3:0] PH_CODE_DONE = 4'h7;
    localparam logic [3:0] PH_CODE_KEEP = 4'h8;
    localparam logic [3:0] PH_CODE_AUTO = 4'he;
    localparam logic [3:0] PH_CODE_NO_WAIT_SETTING = 4'hf;
    localparam logic [3:0] PH_LAST = 4'h7;
    localparam logic [3:0] PH_AUTO_MATCH = 4'h2;
    localparam logic [2:0] DONE_PIPE_LEN = 3'h2;
    localparam logic [31:0] CRC_INIT = 32'hffff_ffff;
    localparam logic [31:0] CRC_POLY = 32'h04c1_1db7;
    localparam logic [31:0] CRC_FIXED = 32'hdefc_defc;
    // enumerations
    localparam logic [1:0] MON_ENABLE = 2'h0;
    localparam logic [1:0] MON_DISABLE = 2'h1;
    localparam logic [1:0] MON_STATUS_ONLY = 2'h2;
    localparam logic [1:0] PORT_AUTO = 2'h0;
    localparam logic [1:0] PORT_TOP = 2'h1;
    localparam logic [1:0] PORT_BOTTOM = 2'h2;
    localparam logic [1:0] SEC_NONE = 2'h0;
    localparam logic [1:0] SEC_LEVEL_ONE = 2'h1;
    localparam logic [1:0] SEC_LEVEL_TWO = 2'h2;
    typedef enum logic [1:0] {CSS_IDLE, CSS_LOAD, CSS_STARTUP, CSS_FINISHED} css_state_t;
endpackage

// >>> core/css_if.sv
`timescale 1ns/1ps
// crc engine link between the control and the checker
interface css_crc_if;
    logic clear;
    logic word_valid;
    logic [31:0] word;
    logic [31:0] crc;
    modport ctrl (output clear, output word_valid, output word, input crc);
    modport eng (input clear, input word_valid, input word, output crc);
endinterface

// >>> core/css_crc.sv
`timescale 1ns/1ps
module css_crc (
    input wire logic pclk,
    input wire logic presetn,
    css_crc_if.eng bus
);
    logic [31:0] next_crc;
    logic [31:0] crc;

    // ========================================
    // bitwise crc32 over one word per clock
    always_comb begin
        logic [31:0] c;
        c = crc;
        for (int i = 31; i >= 0; i--) begin
            if (c[31] ^ bus.word[i]) begin
                c = {c[30:0], 1'b0} ^ css_pkg::CRC_POLY;
            end else begin
                c = {c[30:0], 1'b0};
            end
        end
        next_crc = crc;
        if (bus.clear) begin
            next_crc = css_pkg::CRC_INIT;
        end else if (bus.word_valid) begin
            next_crc = c;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            crc <= css_pkg::CRC_INIT;
        end else begin
            crc <= next_crc;
        end
    end

    assign bus.crc = crc;
endmodule

// >>> core/css_top.sv
// Added by the designer: the APB register port and the register offsets.
`timescale 1ns/1ps
module css_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic clock_manager_lock,
    input wire logic impedance_match,
    output logic done,
    output logic config_error_n,
    output logic global_tristate_hold,
    output logic global_write_enable,
    output logic bram_access_enable,
    output logic global_fabric_hold,
    output logic global_set_reset,
    output logic monitor_power_down,
    output logic boundary_scan_lock,
    output logic monitor_access_en,
    output logic monitor_status_only,
    output logic port_top_sel,
    output logic port_bottom_sel,
    output logic readback_enable
);
    // ========================================
    // pin synchronisers
    logic [1:0] lock_sync;
    logic [1:0] match_sync;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_sync <= 2'h0;
            match_sync <= 2'h0;
        end else begin
            lock_sync <= {lock_sync[0], clock_manager_lock};
            match_sync <= {match_sync[0], impedance_match};
        end
    end
    wire lock_ok = lock_sync[1];
    wire match_ok = match_sync[1];

    // ========================================
    // state
    css_pkg::css_state_t state, next_state;
    logic [31:0] opt, next_opt;
    logic [31:0] phsel, next_phsel;
    logic [31:0] img_crc, next_img_crc;
    logic [3:0] phase, next_phase;
    logic [2:0] pipe_cnt, next_pipe_cnt;
    logic crc_err, next_crc_err;
    logic done_r, next_done;
    logic tri_rel, next_tri_rel;
    logic we_on, next_we_on;
    logic err_n, next_err_n;
    logic [31:0] rdata, next_rdata;
    logic rdy, next_rdy;
    logic slverr, next_slverr;

    css_crc_if crc_bus();
    css_crc u_crc (
        .pclk(pclk),
        .presetn(presetn),
        .bus(crc_bus)
    );

    wire setup = psel && !penable;
    // writes land on the access edge at which pready is seen high
    wire wr = psel && penable && pready && pwrite;
    wire rd = setup && !pwrite;
    wire ctrl_wr = wr && (paddr == css_pkg::CSS_ADDR_CTRL);
    wire start = ctrl_wr && pwdata[css_pkg::CTRL_START];
    wire clear = ctrl_wr && pwdata[css_pkg::CTRL_CLEAR];
    wire data_wr = wr && (paddr == css_pkg::CSS_ADDR_DATA) && (state == css_pkg::CSS_LOAD);
    wire crc_en = opt[css_pkg::OPT_CRC_EN];

    assign crc_bus.clear = clear;
    assign crc_bus.word_valid = data_wr && crc_en;
    assign crc_bus.word = pwdata;

    wire [3:0] ph_done = phsel[css_pkg::PH_DONE_LO +: 4];
    wire [3:0] ph_tri = phsel[css_pkg::PH_TRI_LO +: 4];
    wire [3:0] ph_we = phsel[css_pkg::PH_WE_LO +: 4];
    wire [3:0] ph_lock = phsel[css_pkg::PH_LOCK_LO +: 4];
    wire [3:0] ph_match_raw = phsel[css_pkg::PH_MATCH_LO +: 4];
    logic [3:0] ph_match;
    always_comb begin
        ph_match = ph_match_raw;
        if (ph_match_raw == css_pkg::PH_CODE_AUTO) begin
            ph_match = opt[css_pkg::OPT_DCI_PRESENT] ? css_pkg::PH_AUTO_MATCH
                : css_pkg::PH_CODE_NO_WAIT_SETTING;
        end
    end

    // ========================================
    // sequencer and register next values
    always_comb begin
        logic stall;
        logic done_now;
        stall = 1'b0;
        done_now = 1'b0;
        next_state = state;
        next_opt = opt;
        next_phsel = phsel;
        next_img_crc = img_crc;
        next_phase = phase;
        next_pipe_cnt = pipe_cnt;
        next_crc_err = crc_err;
        next_done = done_r;
        next_tri_rel = tri_rel;
        next_we_on = we_on;
        next_err_n = err_n;
        next_rdy = setup;
        next_slverr = 1'b0;
        next_rdata = 32'h0;
        if (wr && state == css_pkg::CSS_IDLE) begin
            if (paddr == css_pkg::CSS_ADDR_OPT) next_opt = pwdata;
            if (paddr == css_pkg::CSS_ADDR_PHASE) next_phsel = pwdata;
        end
        if (wr && paddr == css_pkg::CSS_ADDR_CRC && state == css_pkg::CSS_LOAD) begin
            next_img_crc = pwdata;
        end
        if (setup && paddr > css_pkg::CSS_ADDR_CALC) next_slverr = 1'b1;
        if (rd) begin
            case (paddr)
                css_pkg::CSS_ADDR_OPT: next_rdata = opt;
                css_pkg::CSS_ADDR_PHASE: next_rdata = phsel;
                css_pkg::CSS_ADDR_CRC: next_rdata = img_crc;
                css_pkg::CSS_ADDR_STATUS: next_rdata = {22'h0, state, phase,
                    done_r, tri_rel, we_on, crc_err};
                css_pkg::CSS_ADDR_CALC: next_rdata = crc_bus.crc;
                default: next_rdata = 32'h0;
            endcase
        end
        case (state)
            css_pkg::CSS_IDLE: begin
                if (start) next_state = css_pkg::CSS_LOAD;
            end
            css_pkg::CSS_LOAD: begin
                if (start) begin
                    if (crc_en && crc_bus.crc != img_crc) begin
                        next_crc_err = 1'b1;
                        if (opt[css_pkg::OPT_ERR_SIG]) next_err_n = 1'b0;
                        next_state = css_pkg::CSS_FINISHED;
                    end else begin
                        next_state = css_pkg::CSS_STARTUP;
                        next_phase = 4'h0;
                    end
                end
            end
            css_pkg::CSS_STARTUP: begin
                if (ph_lock == phase && !lock_ok) stall = 1'b1;
                if (ph_match == phase && !match_ok) stall = 1'b1;
                done_now = (ph_done == phase) && !stall;
                if (done_now) begin
                    next_pipe_cnt = opt[css_pkg::OPT_DONE_PIPE] ? css_pkg::DONE_PIPE_LEN
                        : 3'h0;
                    if (!opt[css_pkg::OPT_DONE_PIPE]) next_done = 1'b1;
                end else if (pipe_cnt != 3'h0) begin
                    next_pipe_cnt = pipe_cnt - 3'h1;
                    if (pipe_cnt == 3'h1) next_done = 1'b1;
                end
                if (!stall) begin
                    if (ph_tri == phase || (ph_tri == css_pkg::PH_CODE_DONE && done_now))
                        next_tri_rel = 1'b1;
                    if (ph_we == phase || (ph_we == css_pkg::PH_CODE_DONE && done_now))
                        next_we_on = 1'b1;
                    if (phase == css_pkg::PH_LAST) begin
                        if (pipe_cnt == 3'h0 && !done_now) next_state = css_pkg::CSS_FINISHED;
                    end else begin
                        next_phase = phase + 4'h1;
                    end
                end
            end
            css_pkg::CSS_FINISHED: begin
                if (clear) begin
                    next_state = css_pkg::CSS_IDLE;
                    next_done = 1'b0;
                    next_tri_rel = 1'b0;
                    next_we_on = 1'b0;
                    next_crc_err = 1'b0;
                    next_err_n = 1'b1;
                    next_phase = 4'h0;
                end
            end
            default: next_state = css_pkg::CSS_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= css_pkg::CSS_IDLE;
            opt <= css_pkg::OPT_RESET;
            phsel <= css_pkg::PHASE_RESET;
            img_crc <= css_pkg::CRC_FIXED;
            phase <= 4'h0;
            pipe_cnt <= 3'h0;
            crc_err <= 1'b0;
            done_r <= 1'b0;
            tri_rel <= 1'b0;
            we_on <= 1'b0;
            err_n <= 1'b1;
            rdata <= 32'h0;
            rdy <= 1'b0;
            slverr <= 1'b0;
        end else begin
            state <= next_state;
            opt <= next_opt;
            phsel <= next_phsel;
            img_crc <= next_img_crc;
            phase <= next_phase;
            pipe_cnt <= next_pipe_cnt;
            crc_err <= next_crc_err;
            done_r <= next_done;
            tri_rel <= next_tri_rel;
            we_on <= next_we_on;
            err_n <= next_err_n;
            rdata <= next_rdata;
            rdy <= next_rdy;
            slverr <= next_slverr;
        end
    end

    // ========================================
    // registered outputs
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            done <= 1'b0;
            config_error_n <= 1'b1;
            global_tristate_hold <= 1'b1;
            global_write_enable <= 1'b0;
            bram_access_enable <= 1'b0;
            global_fabric_hold <= 1'b0;
            global_set_reset <= 1'b0;
            monitor_power_down <= 1'b0;
            boundary_scan_lock <= 1'b0;
            monitor_access_en <= 1'b1;
            monitor_status_only <= 1'b0;
            port_top_sel <= 1'b1;
            port_bottom_sel <= 1'b0;
            readback_enable <= 1'b1;
        end else begin
            prdata <= next_rdata;
            pready <= next_rdy;
            pslverr <= next_slverr;
            done <= next_done;
            config_error_n <= next_err_n;
            global_tristate_hold <= !next_tri_rel;
            global_write_enable <= next_we_on;
            bram_access_enable <= next_we_on;
            global_fabric_hold <= (next_state == css_pkg::CSS_LOAD)
                && !opt[css_pkg::OPT_ACT_RECFG];
            global_set_reset <= (next_state == css_pkg::CSS_LOAD)
                && !opt[css_pkg::OPT_ACT_RECFG];
            monitor_power_down <= opt[css_pkg::OPT_MON_PD];
            boundary_scan_lock <= opt[css_pkg::OPT_JTAG_LOCK]
                && (next_state == css_pkg::CSS_FINISHED);
            monitor_access_en <= opt[css_pkg::OPT_MON_ACC_LO +: 2] != css_pkg::MON_DISABLE;
            monitor_status_only <= opt[css_pkg::OPT_MON_ACC_LO +: 2]
                == css_pkg::MON_STATUS_ONLY;
            port_top_sel <= opt[css_pkg::OPT_PORT_LO +: 2] != css_pkg::PORT_BOTTOM;
            port_bottom_sel <= opt[css_pkg::OPT_PORT_LO +: 2] == css_pkg::PORT_BOTTOM;
            readback_enable <= opt[css_pkg::OPT_SEC_LO +: 2] == css_pkg::SEC_NONE;
        end
    end

    // ========================================
    // checks
    a_crc_refuse: assert property (@(posedge pclk) disable iff (!presetn)
        state == css_pkg::CSS_LOAD && start && crc_en && crc_bus.crc != img_crc
        |=> state == css_pkg::CSS_FINISHED && !done_r)
        else $error("crc mismatch did not refuse");
    a_crc_skip: assert property (@(posedge pclk) disable iff (!presetn)
        !crc_en |=> $stable(crc_bus.crc) || $past(clear))
        else $error("crc ran while disabled");
    a_phase_step: assert property (@(posedge pclk) disable iff (!presetn)
        state == css_pkg::CSS_STARTUP && phase != css_pkg::PH_LAST
        |=> phase == $past(phase) + 4'h1 || phase == $past(phase))
        else $error("phase skipped");
    a_lock_stall: assert property (@(posedge pclk) disable iff (!presetn)
        state == css_pkg::CSS_STARTUP && ph_lock == phase && !lock_ok
        |=> phase == $past(phase))
        else $error("no stall for lock");
    a_match_stall: assert property (@(posedge pclk) disable iff (!presetn)
        state == css_pkg::CSS_STARTUP && ph_match == phase && !match_ok
        |=> phase == $past(phase))
        else $error("no stall for match");
    a_done_phase: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(done_r) |-> opt[css_pkg::OPT_DONE_PIPE] || $past(phase) == ph_done)
        else $error("done in wrong phase");
    a_bram_gate: assert property (@(posedge pclk) disable iff (!presetn)
        !we_on |-> !bram_access_enable && !global_write_enable)
        else $error("bram opened early");
    a_err_pin: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(crc_err) && opt[css_pkg::OPT_ERR_SIG] |=> !config_error_n)
        else $error("error pin not low");
endmodule

// >>> bench/css_src_model.sv
`timescale 1ns/1ps
// ========================================
// far side: clock managers and impedance calibration during startup
module css_src_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic go,
    input wire logic [15:0] lock_dly,
    input wire logic [15:0] match_dly,
    output logic clock_manager_lock,
    output logic impedance_match
);
    logic [15:0] cnt;
    logic [15:0] next_cnt;
    always_comb begin
        next_cnt = go ? cnt + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt <= 16'h0000;
        end else begin
            cnt <= next_cnt;
        end
    end
    // both report only once go has been held high for the set delay
    assign clock_manager_lock = go && (cnt >= lock_dly);
    assign impedance_match = go && (cnt >= match_dly);
endmodule

// >>> bench/config_startup_sequencer_test.sv
`timescale 1ns/1ps
module config_startup_sequencer_test;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, clock_manager_lock, impedance_match, done, config_error_n;
    logic global_tristate_hold, global_write_enable, bram_access_enable, global_fabric_hold;
    logic global_set_reset, monitor_power_down, boundary_scan_lock, monitor_access_en;
    logic monitor_status_only, port_top_sel, port_bottom_sel, readback_enable;
    logic go = 1'b0;
    logic [15:0] lock_dly = 16'h0;
    logic [15:0] match_dly = 16'h0;
    logic dq = 1'b0;
    logic tq = 1'b1;
    logic wq = 1'b0;
    int cyc = 0;
    int t_done, t_tri, t_we, t_start;
    int mismatches = 0;
    int num_checks = 0;
    logic [31:0] img [4] = '{32'h1234_5678, 32'hffff_0000, 32'h0000_0001, 32'ha5c3_3c5a};
    logic [31:0] rd;
    logic er;

    always #20 pclk = ~pclk;

    css_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .clock_manager_lock(clock_manager_lock),
        .impedance_match(impedance_match), .done(done), .config_error_n(config_error_n),
        .global_tristate_hold(global_tristate_hold), .global_write_enable(global_write_enable),
        .bram_access_enable(bram_access_enable), .global_fabric_hold(global_fabric_hold),
        .global_set_reset(global_set_reset), .monitor_power_down(monitor_power_down),
        .boundary_scan_lock(boundary_scan_lock), .monitor_access_en(monitor_access_en),
        .monitor_status_only(monitor_status_only), .port_top_sel(port_top_sel),
        .port_bottom_sel(port_bottom_sel), .readback_enable(readback_enable));
    css_src_model src (.pclk(pclk), .presetn(presetn), .go(go), .lock_dly(lock_dly),
        .match_dly(match_dly), .clock_manager_lock(clock_manager_lock),
        .impedance_match(impedance_match));

    // ========================================
    // edge capture of the startup outputs, in clock cycles
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        dq <= done;
        tq <= global_tristate_hold;
        wq <= global_write_enable;
        if (done && !dq) t_done <= cyc;
        if (!global_tristate_hold && tq) t_tri <= cyc;
        if (global_write_enable && !wq) t_we <= cyc;
    end

    // ========================================
    // checking and bus tasks
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task chb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] r, output logic e);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic e;
        apb(1'b1, a, d, r, e);
    endtask
    function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [31:0] w);
        for (int i = 31; i >= 0; i--) begin
            c = (c[31] ^ w[i]) ? ({c[30:0], 1'b0} ^ css_pkg::CRC_POLY) : {c[30:0], 1'b0};
        end
        return c;
    endfunction
    // ========================================
    // one full load and startup with the given options
    task run_cfg(input logic [31:0] opt, input logic [31:0] ph, input logic bad,
        input logic [15:0] ld, input logic [15:0] md);
        logic [31:0] c;
        int k;
        lock_dly <= ld;
        match_dly <= md;
        wr(css_pkg::CSS_ADDR_OPT, opt);
        wr(css_pkg::CSS_ADDR_PHASE, ph);
        wr(css_pkg::CSS_ADDR_CTRL, 32'h1);
        repeat (2) @(posedge pclk);
        chb(global_fabric_hold, !opt[css_pkg::OPT_ACT_RECFG]);
        chb(global_set_reset, !opt[css_pkg::OPT_ACT_RECFG]);
        c = css_pkg::CRC_INIT;
        for (k = 0; k < 4; k++) begin
            wr(css_pkg::CSS_ADDR_DATA, img[k]);
            c = crc_step(c, img[k]);
        end
        t_done = 9999;
        t_tri = 9999;
        t_we = 9999;
        go <= 1'b1;
        wr(css_pkg::CSS_ADDR_CRC, !opt[0] ? css_pkg::CRC_FIXED : (bad ? ~c : c));
        wr(css_pkg::CSS_ADDR_CTRL, 32'h1);
        t_start = cyc;
        rd = 32'h0;
        while (rd[9:8] !== 2'h3) apb(1'b0, css_pkg::CSS_ADDR_STATUS, 32'h0, rd, er);
        chb(done, !(opt[0] && bad) && ph[3:0] != css_pkg::PH_CODE_KEEP);
        chb(config_error_n, !(opt[0] && bad && opt[css_pkg::OPT_ERR_SIG]));
        chb(global_write_enable, !(opt[0] && bad) && ph[11:8] != css_pkg::PH_CODE_KEEP);
        chb(bram_access_enable, !(opt[0] && bad) && ph[11:8] != css_pkg::PH_CODE_KEEP);
        chb(global_tristate_hold, (opt[0] && bad) || ph[7:4] == css_pkg::PH_CODE_KEEP);
        chb(monitor_power_down, opt[css_pkg::OPT_MON_PD]);
        chb(boundary_scan_lock, opt[css_pkg::OPT_JTAG_LOCK]);
        chb(monitor_access_en, opt[4:3] != css_pkg::MON_DISABLE);
        chb(monitor_status_only, opt[4:3] == css_pkg::MON_STATUS_ONLY);
        chb(port_top_sel, opt[6:5] != css_pkg::PORT_BOTTOM);
        chb(port_bottom_sel, opt[6:5] == css_pkg::PORT_BOTTOM);
        chb(readback_enable, opt[9:8] == css_pkg::SEC_NONE);
        if (opt[0]) begin
            apb(1'b0, css_pkg::CSS_ADDR_CALC, 32'h0, rd, er);
            chk(rd, c);
        end
        wr(css_pkg::CSS_ADDR_OPT, 32'h0);
        apb(1'b0, css_pkg::CSS_ADDR_OPT, 32'h0, rd, er);
        chk(rd, opt);
        wr(css_pkg::CSS_ADDR_CTRL, 32'h2);
        go <= 1'b0;
    endtask

    task end_sim;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        end_sim;
    end

    // ========================================
    // test sequence
    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        chb(done, 1'b0);
        chb(global_tristate_hold, 1'b1);
        chb(global_write_enable, 1'b0);
        chb(config_error_n, 1'b1);
        chb(readback_enable, 1'b1);
        apb(1'b0, css_pkg::CSS_ADDR_OPT, 32'h0, rd, er);
        chk(rd, css_pkg::OPT_RESET);
        apb(1'b0, css_pkg::CSS_ADDR_PHASE, 32'h0, rd, er);
        chk(rd, css_pkg::PHASE_RESET);
        apb(1'b0, 12'h01c, 32'h0, rd, er);
        chk({rd[31:1], er}, 32'h1);
        run_cfg(css_pkg::OPT_RESET, css_pkg::PHASE_RESET, 1'b0, 16'h0, 16'h0);
        chk(t_tri - t_done, 1);
        chk(t_we - t_tri, 1);
        chb(t_done - t_start < 20, 1'b1);
        run_cfg(32'h0000_0957, 32'h000f_f871, 1'b0, 16'h0, 16'h0);
        chk(t_tri, t_done);
        chb(global_write_enable, 1'b0);
        run_cfg(32'h0000_0ea9, css_pkg::PHASE_RESET, 1'b0, 16'h0, 16'h0);
        chk(t_done - t_tri, 1);
        chk(t_done, t_we);
        run_cfg(32'h0000_0800, css_pkg::PHASE_RESET, 1'b0, 16'h0, 16'h0);
        run_cfg(32'h0000_0801, css_pkg::PHASE_RESET, 1'b1, 16'h0, 16'h0);
        chb(global_tristate_hold, 1'b1);
        run_cfg(32'h0000_0001, css_pkg::PHASE_RESET, 1'b1, 16'h0, 16'h0);
        run_cfg(css_pkg::OPT_RESET, 32'h000f_3654, 1'b0, 16'd40, 16'h0);
        chb(t_done - t_start > 30, 1'b1);
        run_cfg(32'h0000_1801, 32'h000e_f654, 1'b0, 16'h0, 16'd40);
        chb(t_done - t_start > 30, 1'b1);
        end_sim;
    end
endmodule
